// *** rtl/ufs_pkg.sv ***
// Package with constants and types for the user flash sector store.
package ufs_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int SECT_W = 8;
    localparam int WORD_COUNT = 512;
    localparam int SECTOR_BITS = 4096;
    localparam int SECT_BIT_POS = 8;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 9'h1ff;
    localparam logic [ADDR_W-1:0] SECT0_LAST = 9'h0ff;
    localparam logic [ADDR_W-1:0] SECT1_FIRST = 9'h100;
    localparam logic [SECT_W-1:0] SECT_IDX_FIRST = 8'h00;
    localparam logic [SECT_W-1:0] SECT_IDX_LAST = 8'hff;
    localparam logic [DATA_W-1:0] BLANK_WORD = 16'hffff;
    localparam logic [DATA_W-1:0] DATA_RST = 16'hffff;
    localparam int ERASE_CYCLES = 256;

    typedef enum logic [1:0] {
        UFS_IDLE = 2'b01,
        UFS_ERASE = 2'b10
    } ufs_state_t;

    // Serial command strobes from user logic, all on sys_clk.
    typedef struct packed {
        logic serIn;
        logic addrShift;
        logic dataShift;
        logic readStb;
        logic progStb;
        logic eraseStb;
    } ufs_cmd_t;

    typedef struct packed {
        ufs_state_t state;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [SECT_W-1:0] eraseIdx;
        logic eraseSect;
        logic busy;
        logic progErr;
    } ufs_regs_t;

endpackage

// *** rtl/ufs_store_array.sv ***
// Word storage of the user flash store: 512 words of 16 bits in flip-flops.
`timescale 1ns/1ps
module ufs_store_array (
    input wire logic sys_clk,
    input wire logic wrEn,
    input wire logic [ufs_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [ufs_pkg::DATA_W-1:0] wrData,
    input wire logic [ufs_pkg::ADDR_W-1:0] rdAddr,
    output logic [ufs_pkg::DATA_W-1:0] rdData
);
    import ufs_pkg::*;

    // Contents are non-volatile, so reset leaves them alone.
    logic [DATA_W-1:0] mem [WORD_COUNT];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rdData = mem[rdAddr];

endmodule // ufs_store_array

// *** rtl/ufs_user_flash_store.sv ***
// User flash store with serial auto-increment access and per-sector erase.
`timescale 1ns/1ps
module ufs_user_flash_store (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ufs_pkg::ufs_cmd_t cmd,
    output logic serOut,
    output logic busy,
    output logic progErr
);
    import ufs_pkg::*;

    ufs_regs_t r_q;
    ufs_regs_t r_d;
    logic wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    logic idle;
    logic eraseGo;
    logic progGo;
    logic readGo;

    // Address step shared by read and program; the last word rolls over to the first.
    function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a);
        nextAddr = ADDR_W'(a + 1'b1);
    endfunction

    // The top address bit names the sector, so each sector spans 256 words.
    function automatic logic sectorOf(input logic [ADDR_W-1:0] a);
        sectorOf = a[SECT_BIT_POS];
    endfunction

    // The array is read at the stored address without delay, so a program can merge
    // with the old word and flag a word that was not erased in the same cycle.
    ufs_store_array u_array (
        .sys_clk(sys_clk),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .rdAddr(r_q.addr),
        .rdData(rdData)
    );

    // Commands are taken only while idle; erase has priority, then program, then read.
    assign idle = (r_q.state == UFS_IDLE);
    assign eraseGo = idle && cmd.eraseStb;
    assign progGo = idle && !cmd.eraseStb && cmd.progStb;
    assign readGo = idle && !cmd.eraseStb && !cmd.progStb && cmd.readStb;

    always_comb begin
        r_d = r_q;
        wrEn = 1'b0;
        wrAddr = r_q.addr;
        wrData = BLANK_WORD;
        case (r_q.state)
            UFS_IDLE: begin
                if (eraseGo) begin
                    r_d.state = UFS_ERASE;
                    r_d.eraseSect = sectorOf(r_q.addr);
                    r_d.eraseIdx = SECT_IDX_FIRST;
                    r_d.busy = 1'b1;
                    r_d.progErr = 1'b0;
                end else if (progGo) begin
                    // Programming can only clear bits, as in a real flash cell.
                    wrEn = 1'b1;
                    wrData = rdData & r_q.data;
                    r_d.addr = nextAddr(r_q.addr);
                    if (rdData != BLANK_WORD) begin
                        r_d.progErr = 1'b1;
                    end
                end else if (readGo) begin
                    r_d.data = rdData;
                    r_d.addr = nextAddr(r_q.addr);
                end else begin
                    if (cmd.addrShift) begin
                        r_d.addr = {r_q.addr[ADDR_W-2:0], cmd.serIn};
                    end
                    if (cmd.dataShift) begin
                        r_d.data = {r_q.data[DATA_W-2:0], cmd.serIn};
                    end
                end
            end
            UFS_ERASE: begin
                // One word per cycle, only inside the chosen sector.
                wrEn = 1'b1;
                wrAddr = {r_q.eraseSect, r_q.eraseIdx};
                wrData = BLANK_WORD;
                r_d.eraseIdx = SECT_W'(r_q.eraseIdx + 1'b1);
                if (r_q.eraseIdx == SECT_IDX_LAST) begin
                    r_d.state = UFS_IDLE;
                    r_d.busy = 1'b0;
                end
            end
            default: begin
                r_d.state = UFS_IDLE;
                r_d.busy = 1'b0;
            end
        endcase
    end

    // Reset leaves the array alone, since its contents stand for non-volatile cells.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_q.state <= UFS_IDLE;
            r_q.addr <= ADDR_FIRST;
            r_q.data <= DATA_RST;
            r_q.eraseIdx <= SECT_IDX_FIRST;
            r_q.eraseSect <= 1'b0;
            r_q.busy <= 1'b0;
            r_q.progErr <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // Every output is a bit of the state register.
    assign serOut = r_q.data[DATA_W-1];
    assign busy = r_q.busy;
    assign progErr = r_q.progErr;

    // The checks below are switched off while reset is held.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    AST_ADDR_WRAP: assert property (
        (readGo || progGo) && r_q.addr == ADDR_LAST |=> r_q.addr == ADDR_FIRST)
        else $error("Address did not wrap from 1FFh to 000h.");

    AST_ERASE_IN_SECTOR: assert property (
        r_q.state == UFS_ERASE |-> wrEn && wrAddr[SECT_BIT_POS] == r_q.eraseSect)
        else $error("Erase write left the selected sector.");

    AST_ERASE_SECTOR_PICK: assert property (
        eraseGo |=> r_q.eraseSect == $past(r_q.addr[SECT_BIT_POS]))
        else $error("Erased sector does not follow address bit 8.");

    AST_READ_WORD: assert property (
        readGo |=> r_q.data == $past(rdData))
        else $error("Read did not load the full stored word.");

    AST_ERASE_LENGTH: assert property (
        eraseGo |=> busy [*8] ##248 busy ##1 !busy)
        else $error("Sector erase did not take 256 cycles.");

    AST_ERASE_BLANKS: assert property (
        r_q.state == UFS_ERASE |-> wrData == BLANK_WORD)
        else $error("Erase wrote a non-blank word.");

    AST_PROG_ERR: assert property (
        progGo && rdData != BLANK_WORD |=> progErr)
        else $error("Program into an unerased word was not flagged.");

    AST_OTHER_SECTOR_KEPT: assert property (
        busy && wrEn |-> sectorOf(wrAddr) == r_q.eraseSect && !progGo && !readGo)
        else $error("Write during erase touched the other sector.");

    AST_AUTO_INC: assert property (
        readGo || progGo |=> r_q.addr == nextAddr($past(r_q.addr)))
        else $error("Address did not advance after a word access.");

    AST_ADDR_SHIFT: assert property (
        idle && cmd.addrShift && !cmd.eraseStb && !cmd.progStb && !cmd.readStb |=>
        r_q.addr == {$past(r_q.addr[ADDR_W-2:0]), $past(cmd.serIn)})
        else $error("Address shift did not take the serial bit.");

    AST_DATA_SHIFT: assert property (
        idle && cmd.dataShift && !cmd.eraseStb && !cmd.progStb && !cmd.readStb |=>
        r_q.data == {$past(r_q.data[DATA_W-2:0]), $past(cmd.serIn)})
        else $error("Data shift did not take the serial bit.");

    AST_PROG_WRITE: assert property (
        progGo |-> wrEn && wrAddr == r_q.addr && wrData == (rdData & r_q.data))
        else $error("Program did not write the merged word at the stored address.");

    AST_ERR_CLEAR: assert property (
        eraseGo |=> !progErr)
        else $error("Program error flag not cleared by an erase start.");

    AST_ERR_STICKY: assert property (
        progErr && !eraseGo |=> progErr)
        else $error("Program error flag dropped without an erase.");

    AST_ERASE_START_IDX: assert property (
        eraseGo |=> r_q.state == UFS_ERASE && r_q.eraseIdx == SECT_IDX_FIRST)
        else $error("Erase did not start at the first word of the sector.");

    AST_ERASE_STEP: assert property (
        r_q.state == UFS_ERASE && r_q.eraseIdx != SECT_IDX_LAST |=>
        r_q.state == UFS_ERASE && r_q.eraseIdx == SECT_W'($past(r_q.eraseIdx) + 1'b1))
        else $error("Erase skipped or repeated a word.");

    AST_ERASE_END: assert property (
        r_q.state == UFS_ERASE && r_q.eraseIdx == SECT_IDX_LAST |=> !busy && idle)
        else $error("Erase did not end after the last word of the sector.");

    AST_BUSY_IS_ERASE: assert property (
        busy == (r_q.state == UFS_ERASE))
        else $error("Busy does not match the erase state.");

    AST_BUSY_FREEZE: assert property (
        busy |=> $stable(r_q.addr) && $stable(r_q.data))
        else $error("Address or data changed while an erase was running.");

    AST_STATE_LEGAL: assert property (
        r_q.state == UFS_IDLE || r_q.state == UFS_ERASE)
        else $error("State register holds an illegal code.");

    AST_READ_NO_WRITE: assert property (
        readGo |-> !wrEn)
        else $error("A read wrote into the array.");

    AST_WRITE_CAUSE: assert property (
        !progGo && r_q.state != UFS_ERASE |-> !wrEn)
        else $error("Array written with no program and no erase.");

    // Main scenarios that a run should reach.
    COV_ERASE_SECT1: cover property (eraseGo && r_q.addr[SECT_BIT_POS]);
    COV_PROG_BLANK: cover property (progGo && rdData == BLANK_WORD);
    COV_READ_BACK: cover property (progGo ##[1:40] readGo);
    COV_BUSY_REFUSED: cover property (busy && cmd.progStb);
    COV_ADDR_WRAP: cover property (progGo && r_q.addr == ADDR_LAST);

endmodule // ufs_user_flash_store

// *** test/ufs_user_model.sv ***
// Model of the user logic that drives the serial command port of the flash store.
`timescale 1ns/1ps
module ufs_user_model (
    input wire logic sys_clk,
    input wire logic serOut,
    output ufs_pkg::ufs_cmd_t cmd
);
    import ufs_pkg::*;
    initial cmd = '0;
    // Shifts the low n bits of v, most significant first, into address or data.
    task automatic shiftIn(input logic [15:0] v, input int n, input logic toAddr);
        ufs_cmd_t c;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge sys_clk);
            c = '0;
            c.serIn = v[i];
            c.addrShift = toAddr;
            c.dataShift = !toAddr;
            cmd = c;
        end
        @(negedge sys_clk);
        cmd = '0;
    endtask
    // Bit k of the command: 2 read, 1 program, 0 erase.
    task automatic pulse(input int k);
        ufs_cmd_t c;
        c = '0;
        c[k] = 1'b1;
        @(negedge sys_clk);
        cmd = c;
        @(negedge sys_clk);
        cmd = '0;
    endtask
    // Each bit is written once per cycle, so the port never glitches within a time step.
    task automatic readWord(output logic [15:0] v);
        ufs_cmd_t c;
        c = '0;
        c.readStb = 1'b1;
        @(negedge sys_clk);
        cmd = c;
        for (int i = 15; i >= 0; i--) begin
            @(negedge sys_clk);
            v[i] = serOut;
            c = '0;
            c.dataShift = (i > 0);
            c.serIn = (i > 0) && !serOut;
            cmd = c;
        end
    endtask
endmodule // ufs_user_model

// *** test/tb.sv ***
// Self-checking testbench for the user flash sector store.
`timescale 1ns/1ps
module tb;
    import ufs_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    ufs_cmd_t cmd;
    logic serOut;
    logic busy;
    logic progErr;
    int bad_count = 0;
    int num_checks = 0;
    always #25 sys_clk = ~sys_clk;
    ufs_user_flash_store i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd(cmd), .serOut(serOut),
        .busy(busy), .progErr(progErr));
    ufs_user_model i_usr (.sys_clk(sys_clk), .serOut(serOut), .cmd(cmd));
    task automatic conclude();
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic checkVal(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic setAddr(input logic [8:0] a);
        i_usr.shiftIn({7'h00, a}, ADDR_W, 1'b1);
    endtask
    task automatic progWord(input logic [15:0] d);
        i_usr.shiftIn(d, DATA_W, 1'b0);
        i_usr.pulse(1);
    endtask
    task automatic readCheck(input string what, input logic [15:0] exp);
        logic [15:0] v;
        i_usr.readWord(v);
        checkVal(what, exp, v);
    endtask
    task automatic waitErase(input int expCycles);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        checkVal("erase cycles", 16'(expCycles), n[15:0]);
        checkVal("progErr after erase", 16'h0000, {15'h0000, progErr});
    endtask
    task automatic eraseSector(input logic s);
        setAddr({s, 8'h00});
        i_usr.pulse(0);
        waitErase(ERASE_CYCLES);
    endtask
    task automatic testSectorEdge();
        eraseSector(1'b0);
        eraseSector(1'b1);
        setAddr(9'h0ff);
        progWord(16'ha5a5);
        progWord(16'h5a5a);
        setAddr(9'h0ff);
        readCheck("word 0ff", 16'ha5a5);
        readCheck("word 100", 16'h5a5a);
    endtask
    task automatic testIsolation();
        eraseSector(1'b0);
        setAddr(9'h0ff);
        readCheck("erased 0ff", BLANK_WORD);
        readCheck("kept 100", 16'h5a5a);
    endtask
    task automatic testWrap();
        setAddr(9'h1fe);
        progWord(16'h1234);
        progWord(16'h8001);
        progWord(16'h00ff);
        setAddr(ADDR_LAST);
        readCheck("word 1ff", 16'h8001);
        readCheck("wrapped 000", 16'h00ff);
        setAddr(ADDR_LAST);
        progWord(16'h0000);
        checkVal("progErr on reprogram", 16'h0001, {15'h0000, progErr});
        eraseSector(1'b1);
        setAddr(9'h1fe);
        readCheck("erased 1fe", BLANK_WORD);
        readCheck("erased 1ff", BLANK_WORD);
        readCheck("sector 0 kept", 16'h00ff);
    endtask
    // Commands given during an erase must be dropped; they use twelve of its cycles.
    task automatic testRefusal();
        setAddr(9'h1fe);
        progWord(16'h3c3c);
        checkVal("progErr on blank program", 16'h0000, {15'h0000, progErr});
        setAddr(9'h000);
        i_usr.pulse(0);
        setAddr(9'h1fe);
        i_usr.pulse(1);
        checkVal("busy during erase", 16'h0001, {15'h0000, busy});
        waitErase(ERASE_CYCLES - 12);
        readCheck("erased 000", BLANK_WORD);
        setAddr(9'h1fe);
        readCheck("sector 1 kept", 16'h3c3c);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        testSectorEdge();
        testIsolation();
        testWrap();
        testRefusal();
        conclude();
    end
endmodule // tb
